// file: sec_pkg.sv
// shared constants and types of the serial eeprom command engine
package sec_pkg;

    // decoded instruction of the current frame
    typedef enum logic [2:0] {
        SEC_CMD_NONE,
        SEC_CMD_WRITE_ENABLE,
        SEC_CMD_WRITE_DISABLE,
        SEC_CMD_STATUS_READ,
        SEC_CMD_STATUS_WRITE,
        SEC_CMD_MEM_READ,
        SEC_CMD_MEM_WRITE
    } sec_cmd_t;

    // internal write sequencer
    typedef enum logic [1:0] {
        SEC_WR_IDLE,
        SEC_WR_COPY,
        SEC_WR_PROGRAM
    } sec_wr_state_t;

    // opcode layout: upper nibble zero, bit 3 don't care or top address bit
    localparam logic [3:0] OPCODE_HI          = 4'h0;
    localparam logic [2:0] OP_WRITE_ENABLE    = 3'h6;
    localparam logic [2:0] OP_WRITE_DISABLE   = 3'h4;
    localparam logic [2:0] OP_STATUS_READ     = 3'h5;
    localparam logic [2:0] OP_STATUS_WRITE    = 3'h1;
    localparam logic [2:0] OP_MEM_READ        = 3'h3;
    localparam logic [2:0] OP_MEM_WRITE       = 3'h2;
    localparam int         OP_ADDR_HI_BIT     = 3;

    // status byte layout
    localparam logic [3:0] STATUS_ONES        = 4'hf;
    localparam int         ST_WIP             = 0;
    localparam int         ST_WEL             = 1;
    localparam int         ST_BP_LO           = 2;
    localparam int         ST_BP_HI           = 3;
    localparam logic [1:0] BP_RESET           = 2'h0;

    // block protect codes
    localparam logic [1:0] BP_NONE            = 2'h0;
    localparam logic [1:0] BP_QUARTER         = 2'h1;
    localparam logic [1:0] BP_HALF            = 2'h2;
    localparam logic [1:0] BP_ALL             = 2'h3;

    // frame length checks, in whole bytes
    localparam logic [2:0] BIT_ALIGNED        = 3'h0;
    localparam logic [2:0] BIT_LAST           = 3'h7;
    localparam logic [7:0] BYTES_CMD_ONLY     = 8'h01;
    localparam logic [7:0] BYTES_STATUS_WRITE = 8'h02;
    localparam logic [7:0] BYTES_WRITE_MIN    = 8'h03;
    localparam logic [7:0] BYTES_SAT          = 8'hff;
    localparam logic [7:0] BYTE_OPCODE        = 8'h00;
    localparam logic [7:0] BYTE_ADDR          = 8'h01;
    localparam logic [7:0] BYTES_STATUS_OUT   = 8'h01;
    localparam logic [7:0] BYTES_DATA_OUT     = 8'h02;

    // page buffer
    localparam int         PAGE_ADDR_W        = 4;
    localparam int         PAGE_BYTES         = 16;

    // timing
    localparam int         CLK_PERIOD_NS      = 20;
    localparam int         INTERNAL_WRITE_TIME_NS = 5000000;
    localparam int         DEFAULT_ADDR_W     = 9;

endpackage : sec_pkg

// file: sec_engine.sv
// instruction engine of a serial eeprom: spi frame logic and internal write sequencer
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RULE_01 - disable command needs exactly eight clocks
// RULE_02 - latch cleared at reset, disable, completion, protect
// RULE_03 - status byte repeats until chip select rises
// RULE_04 - status read accepted anytime, bits live
// RULE_05 - status reads return ones in top nibble
// RULE_06 - status write changes only protect bits
// RULE_07 - status write needs latch and protect high
// RULE_08 - status write needs exactly sixteen clocks
// RULE_09 - progress bit high during write, latch cleared after
// RULE_10 - old protect bits shown until write finishes
// RULE_11 - memory read autoincrements, wraps at top
// RULE_12 - top address bit in opcode, or ignored
// RULE_13 - memory read ignored during write, abortable
// RULE_14 - chip select rise starts write, completion clears
// RULE_15 - up to sixteen bytes programmed as page
// RULE_16 - low four address bits wrap within page
// RULE_17 - write rejected: no latch, busy, protected, pin
// RULE_18 - memory write needs sixteen plus bytes clocks
// RULE_19 - protect pin low blocks writes, clears latch
// RULE_20 - protect code selects none, quarter, half, all
// RULE_21 - hold floats output, chip select aborts
// RULE_22 - hold takes effect with serial clock low
// RULE_23 - six opcodes, invalid opcode deselects
// RULE_24 - status bit layout, latch set by enable
// RULE_25 - sample on rising, shift out falling
// RULE_26 - output driven only in output phases
module sec_engine #(
    parameter int ADDR_W        = sec_pkg::DEFAULT_ADDR_W,        // 7, 8 or 9 address bits
    parameter int WRITE_TIME_NS = sec_pkg::INTERNAL_WRITE_TIME_NS // internal write time
) (
    input  wire logic ref_clk,        // system clock, 50 MHz
    input  wire logic sys_rst,        // power-on reset, async, active high
    input  wire logic linkClk,        // serial clock from the host
    input  wire logic chipSelN,       // chip select, active low
    input  wire logic serialIn,       // serial data in
    input  wire logic holdN,          // hold, active low
    input  wire logic writeProtectN,  // write protect, active low
    output logic      serialOut,      // serial data out
    output logic      serialOutOeN,   // output enable, low while driving
    output logic      writeInProgress,// progress bit, system clock domain
    output logic      writeEnabled    // enable latch, system clock domain
);
    import sec_pkg::*;

    localparam int WRITE_CYCLES_RAW = WRITE_TIME_NS / CLK_PERIOD_NS;
    localparam int WRITE_CYCLES     = (WRITE_CYCLES_RAW < 1) ? 1 : WRITE_CYCLES_RAW;
    localparam int TIMER_W          = $clog2(WRITE_CYCLES + 1);
    localparam int MEM_DEPTH        = 1 << ADDR_W;
    localparam int BASE_W           = ADDR_W - PAGE_ADDR_W;

    // refuse address widths the decoder cannot serve
    if (ADDR_W < 7 || ADDR_W > 9) begin : gBadAddrW
        $error("ADDR_W must be 7, 8 or 9");
    end

    // decode one opcode byte; bit 3 is never part of the match
    function automatic sec_cmd_t decodeOpcode(input logic [7:0] op);
        sec_cmd_t c;
        c = SEC_CMD_NONE;
        if (op[7:4] == OPCODE_HI) begin
            unique case (op[2:0])
                OP_WRITE_ENABLE:  c = SEC_CMD_WRITE_ENABLE;
                OP_WRITE_DISABLE: c = SEC_CMD_WRITE_DISABLE;
                OP_STATUS_READ:   c = SEC_CMD_STATUS_READ;
                OP_STATUS_WRITE:  c = SEC_CMD_STATUS_WRITE;
                OP_MEM_READ:      c = SEC_CMD_MEM_READ;
                OP_MEM_WRITE:     c = SEC_CMD_MEM_WRITE;
                default:          c = SEC_CMD_NONE;
            endcase
        end
        return c;
    endfunction : decodeOpcode

    // protected region for a given protect code
    function automatic logic isProtected(input logic [ADDR_W-1:0] a, input logic [1:0] bp);
        logic p;
        p = 1'b0;
        unique case (bp)
            BP_NONE:    p = 1'b0;
            BP_QUARTER: p = a[ADDR_W-1] & a[ADDR_W-2];
            BP_HALF:    p = a[ADDR_W-1];
            BP_ALL:     p = 1'b1;
        endcase
        return p;
    endfunction : isProtected

    // array and page buffer
    logic [7:0]              memArray [MEM_DEPTH];   // written on ref_clk, read on linkClk
    logic [7:0]              pageBuf_q [PAGE_BYTES]; // written on linkClk, read on ref_clk

    // link domain state
    logic                    frameRst;         // chip select high or reset
    logic                    armed_q;          // a rising edge has been seen in this frame
    logic                    frameTog_q;       // flips per clocked frame
    logic [2:0]              bit_q;            // bits of current byte
    logic [7:0]              byte_q;           // whole bytes, saturating
    logic [7:0]              shift_q;          // input shifter
    sec_cmd_t                cmd_q;            // decoded command
    logic                    opAddrHi_q;       // opcode bit carrying the top address bit
    logic [ADDR_W-1:0]       addr_q;           // address counter
    logic [7:0]              statusData_q;     // byte received by status write
    logic [PAGE_BYTES-1:0]   pageMask_q;       // page slots filled in this frame
    logic [3:0]              stMeta_q;         // status sync, first stage
    logic [3:0]              stSync_q;         // status sync, second stage

    // system domain state
    logic [2:0]              csSync_q;         // chip select sync and edge stage
    logic [1:0]              wpSync_q;         // protect pin sync
    logic [1:0]              holdSync_q;       // hold pin sync
    sec_wr_state_t           wrState_q;        // write sequencer
    sec_wr_state_t           wrState_d;
    logic [TIMER_W-1:0]      timer_q;          // program time left
    logic [PAGE_ADDR_W-1:0]  copyIdx_q;        // page copy index
    logic [BASE_W-1:0]       pageBase_q;       // upper address of the page
    logic [1:0]              bp_q;             // visible protect bits
    logic [1:0]              bpNext_q;         // protect bits being programmed
    logic                    bpPending_q;      // a status write is in flight
    logic                    wel_q;            // write enable latch
    logic                    seenTog_q;        // last judged toggle, no replay

    // link domain combinational view of the frame
    logic                    firstEdge;
    logic [2:0]              bitNow;
    logic [7:0]              byteNow;
    logic [7:0]              shiftIn;
    logic [ADDR_W-1:0]       addrLoad;
    logic                    wipSeen;
    logic                    outPhase;
    logic [7:0]              outByte;

    assign frameRst  = sys_rst | chipSelN;
    assign firstEdge = ~armed_q;
    assign bitNow    = firstEdge ? BIT_ALIGNED : bit_q;
    assign byteNow   = firstEdge ? BYTE_OPCODE : byte_q;
    assign shiftIn   = {shift_q[6:0], serialIn};
    assign addrLoad  = ADDR_W'({opAddrHi_q, shiftIn});
    assign wipSeen   = stSync_q[ST_WIP];

    // frame start marker; chip select high clears it so stale counts never count
    always_ff @(posedge linkClk or posedge frameRst) begin
        if (frameRst) begin
            armed_q <= 1'b0;
        end else if (holdN) begin
            armed_q <= 1'b1;
        end
    end

    // status bits into the link domain; only sampled while clocks arrive
    always_ff @(posedge linkClk or posedge sys_rst) begin
        if (sys_rst) begin
            stMeta_q <= 4'h0;
            stSync_q <= 4'h0;
        end else begin
            stMeta_q <= {bp_q, wel_q, wrState_q != SEC_WR_IDLE};
            stSync_q <= stMeta_q;
        end
    end

    // input shifter and frame decoder, rising edge sampling
    always_ff @(posedge linkClk or posedge sys_rst) begin
        if (sys_rst) begin
            bit_q        <= BIT_ALIGNED;
            byte_q       <= BYTE_OPCODE;
            shift_q      <= 8'h00;
            cmd_q        <= SEC_CMD_NONE;
            opAddrHi_q   <= 1'b0;
            addr_q       <= '0;
            statusData_q <= 8'h00;
            pageMask_q   <= '0;
            frameTog_q   <= 1'b0;
        end else if (holdN) begin                                   // RULE_21
            bit_q   <= 3'(bitNow + 3'h1);                           // RULE_25
            shift_q <= shiftIn;
            if (firstEdge) begin
                cmd_q      <= SEC_CMD_NONE;
                pageMask_q <= '0;
                byte_q     <= BYTE_OPCODE;
                frameTog_q <= ~frameTog_q;
            end
            if (bitNow == BIT_LAST) begin
                byte_q <= (byteNow == BYTES_SAT) ? BYTES_SAT : 8'(byteNow + 8'h01);
                if (byteNow == BYTE_OPCODE) begin
                    // a bad opcode leaves the command empty: rest of frame ignored
                    cmd_q <= decodeOpcode(shiftIn);                 // RULE_23
                    if (decodeOpcode(shiftIn) == SEC_CMD_MEM_READ && wipSeen) begin
                        cmd_q <= SEC_CMD_NONE;                      // RULE_13
                    end
                    opAddrHi_q <= shiftIn[OP_ADDR_HI_BIT];          // RULE_12
                end else if (byteNow == BYTE_ADDR) begin
                    if (cmd_q == SEC_CMD_MEM_READ || cmd_q == SEC_CMD_MEM_WRITE) begin
                        addr_q <= addrLoad;                         // RULE_11 RULE_12
                    end
                    if (cmd_q == SEC_CMD_STATUS_WRITE) begin
                        statusData_q <= shiftIn;
                    end
                end else if (cmd_q == SEC_CMD_MEM_READ) begin
                    // full width increment wraps from the last address to zero
                    addr_q <= ADDR_W'(addr_q + 1'b1);               // RULE_11
                end else if (cmd_q == SEC_CMD_MEM_WRITE && !wipSeen) begin
                    // the buffer is frozen while a copy may still read it
                    pageMask_q[addr_q[PAGE_ADDR_W-1:0]] <= 1'b1;    // RULE_15
                    addr_q[PAGE_ADDR_W-1:0] <= PAGE_ADDR_W'(addr_q[PAGE_ADDR_W-1:0] + 1'b1); // RULE_16
                end
            end
        end
    end

    // page slots, overwritten when the low address bits wrap
    always_ff @(posedge linkClk) begin
        if (holdN && armed_q && bit_q == BIT_LAST && byte_q >= BYTES_WRITE_MIN - 8'h01
            && cmd_q == SEC_CMD_MEM_WRITE && !wipSeen) begin
            pageBuf_q[addr_q[PAGE_ADDR_W-1:0]] <= shiftIn;          // RULE_16
        end
    end

    // output phase and byte being shifted out
    always_comb begin
        outPhase = 1'b0;
        outByte  = memArray[addr_q];
        if (armed_q && cmd_q == SEC_CMD_STATUS_READ && byte_q >= BYTES_STATUS_OUT) begin
            outPhase = 1'b1;                                        // RULE_03 RULE_04
            outByte  = {STATUS_ONES, stSync_q};                     // RULE_05 RULE_24
        end else if (armed_q && cmd_q == SEC_CMD_MEM_READ && byte_q >= BYTES_DATA_OUT) begin
            outPhase = 1'b1;
        end
    end

    // output shifter on falling edges; floats whenever chip select is high
    always_ff @(negedge linkClk or posedge frameRst) begin
        if (frameRst) begin
            serialOut    <= 1'b0;
            serialOutOeN <= 1'b1;                                   // RULE_26
        end else begin
            // hold is seen at the falling edge, so the pin floats no earlier than that
            serialOutOeN <= ~(outPhase & holdN);                    // RULE_21 RULE_22 RULE_26
            if (holdN) begin
                serialOut <= outByte[3'(BIT_LAST - bit_q)];         // RULE_25
            end
        end
    end

    // pin synchronisers in the system domain
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            csSync_q   <= 3'h7;
            wpSync_q   <= 2'h3;
            holdSync_q <= 2'h3;
        end else begin
            csSync_q   <= {csSync_q[1:0], chipSelN};
            wpSync_q   <= {wpSync_q[0], writeProtectN};
            holdSync_q <= {holdSync_q[0], holdN};
        end
    end

    // frame end, as seen by the system clock; frame registers are quiet by then
    logic csRise;
    logic frameOk;
    logic wpLow;
    logic cmdOnly;
    logic startStatus;
    logic startMem;
    logic writeDone;

    assign csRise   = csSync_q[1] & ~csSync_q[2];
    assign frameOk  = csRise & holdSync_q[1] & (bit_q == BIT_ALIGNED)       // RULE_21
                    & (frameTog_q ^ seenTog_q);
    assign wpLow    = ~wpSync_q[1];
    assign cmdOnly  = frameOk & (byte_q == BYTES_CMD_ONLY);                 // RULE_01
    assign startStatus = frameOk & (cmd_q == SEC_CMD_STATUS_WRITE)
                       & (byte_q == BYTES_STATUS_WRITE)                     // RULE_08
                       & wel_q & ~wpLow & (wrState_q == SEC_WR_IDLE);       // RULE_07
    assign startMem = frameOk & (cmd_q == SEC_CMD_MEM_WRITE)
                    & (byte_q >= BYTES_WRITE_MIN)                           // RULE_18
                    & wel_q & ~wpLow & (wrState_q == SEC_WR_IDLE)           // RULE_17 RULE_19
                    & ~isProtected(addr_q, bp_q);                           // RULE_20
    assign writeDone = (wrState_q == SEC_WR_PROGRAM) && (timer_q == TIMER_W'(1));

    // write sequencer next state
    always_comb begin
        wrState_d = wrState_q;
        unique case (wrState_q)
            SEC_WR_IDLE: begin
                if (startMem) begin
                    wrState_d = SEC_WR_COPY;                        // RULE_14
                end else if (startStatus) begin
                    wrState_d = SEC_WR_PROGRAM;
                end
            end
            SEC_WR_COPY: begin
                if (copyIdx_q == PAGE_ADDR_W'(PAGE_BYTES - 1)) begin
                    wrState_d = SEC_WR_PROGRAM;
                end
            end
            SEC_WR_PROGRAM: begin
                if (writeDone) begin
                    wrState_d = SEC_WR_IDLE;
                end
            end
        endcase
    end

    // sequencer registers, page copy index and program timer
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wrState_q       <= SEC_WR_IDLE;
            timer_q         <= '0;
            copyIdx_q       <= '0;
            pageBase_q      <= '0;
            writeInProgress <= 1'b0;
            seenTog_q       <= 1'b0;
        end else begin
            wrState_q       <= wrState_d;
            seenTog_q       <= csRise ? frameTog_q : seenTog_q;
            writeInProgress <= (wrState_d != SEC_WR_IDLE);          // RULE_09
            if (startMem) begin
                pageBase_q <= addr_q[ADDR_W-1:PAGE_ADDR_W];         // RULE_16
                copyIdx_q  <= '0;
            end else if (wrState_q == SEC_WR_COPY) begin
                copyIdx_q  <= PAGE_ADDR_W'(copyIdx_q + 1'b1);
            end
            if (wrState_q != SEC_WR_PROGRAM && wrState_d == SEC_WR_PROGRAM) begin
                timer_q <= TIMER_W'(WRITE_CYCLES);
            end else if (wrState_q == SEC_WR_PROGRAM) begin
                timer_q <= TIMER_W'(timer_q - 1'b1);
            end
        end
    end

    // array write: one page slot per cycle, only slots filled by the frame
    always_ff @(posedge ref_clk) begin
        if (wrState_q == SEC_WR_COPY && pageMask_q[copyIdx_q]) begin
            memArray[{pageBase_q, copyIdx_q}] <= pageBuf_q[copyIdx_q];  // RULE_15
        end
    end

    // protect bits: old value stays visible until the program time ends
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bp_q        <= BP_RESET;
            bpNext_q    <= BP_RESET;
            bpPending_q <= 1'b0;
        end else begin
            if (startStatus) begin
                bpNext_q    <= statusData_q[ST_BP_HI:ST_BP_LO];     // RULE_06
                bpPending_q <= 1'b1;
            end else if (writeDone && bpPending_q) begin
                bp_q        <= bpNext_q;                            // RULE_10
                bpPending_q <= 1'b0;
            end
        end
    end

    // write enable latch
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wel_q <= 1'b0;                                          // RULE_02
        end else if (wpLow) begin
            wel_q <= 1'b0;                                          // RULE_19
        end else if (cmdOnly && cmd_q == SEC_CMD_WRITE_ENABLE) begin
            wel_q <= 1'b1;                                          // RULE_24
        end else if (writeDone) begin
            wel_q <= 1'b0;                                          // RULE_09 RULE_14
        end else if (cmdOnly && cmd_q == SEC_CMD_WRITE_DISABLE) begin
            wel_q <= 1'b0;                                          // RULE_01 RULE_02
        end
    end

    // latch copy for the outside
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            writeEnabled <= 1'b0;
        end else begin
            writeEnabled <= wel_q;
        end
    end

endmodule : sec_engine
`default_nettype wire

// file: sec_engine_chk.sv
// pin level assertions of the eeprom command engine
`timescale 1ns/1ps
`default_nettype none
module sec_engine_chk #(
    parameter int WRITE_TIME_NS = 2000 // internal write time
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic linkClk,
    input wire logic chipSelN,
    input wire logic serialIn,
    input wire logic holdN,
    input wire logic writeProtectN,
    input wire logic serialOut,
    input wire logic serialOutOeN,
    input wire logic writeInProgress,
    input wire logic writeEnabled
);
    int wipCnt;
    // counts busy cycles so a write cut short is seen
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst)
            wipCnt <= 0;
        else
            wipCnt <= writeInProgress ? wipCnt + 1 : 0;
    end
    a_oe_when_idle: assert property (@(posedge ref_clk) disable iff (sys_rst)
        chipSelN |-> serialOutOeN) else $error("output driven while deselected");
    a_oe_in_frame: assert property (@(posedge linkClk) disable iff (sys_rst)
        !serialOutOeN |-> !chipSelN) else $error("output driven outside a frame");
    a_pin_holds_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !writeProtectN [*6] |-> !writeEnabled) else $error("latch set under protect");
    a_write_at_deselect: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $rose(writeInProgress) |-> chipSelN) else $error("write began in a frame");
    a_write_needs_latch: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $rose(writeInProgress) |-> writeEnabled) else $error("write without latch");
    a_done_clears_latch: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $fell(writeInProgress) |-> ##[0:2] !writeEnabled) else $error("latch kept");
    a_write_full_time: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $fell(writeInProgress) |-> wipCnt >= WRITE_TIME_NS / 20 - 1)
        else $error("internal write too short");
    a_latch_at_deselect: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $rose(writeEnabled) |-> chipSelN) else $error("latch set in a frame");
    c_write: cover property (@(posedge ref_clk) $rose(writeInProgress));
    c_latch: cover property (@(posedge ref_clk) $rose(writeEnabled));
    c_output: cover property (@(posedge linkClk) !serialOutOeN);
endmodule : sec_engine_chk
bind sec_engine sec_engine_chk #(.WRITE_TIME_NS(WRITE_TIME_NS)) sec_engine_chk_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .linkClk(linkClk), .chipSelN(chipSelN),
    .serialIn(serialIn), .holdN(holdN), .writeProtectN(writeProtectN),
    .serialOut(serialOut), .serialOutOeN(serialOutOeN),
    .writeInProgress(writeInProgress), .writeEnabled(writeEnabled));
`default_nettype wire

// file: sec_spi_host.sv
// spi host model that frames commands to the eeprom engine
`timescale 1ns/1ps
`default_nettype none
module sec_spi_host (
    output var logic linkClk,
    output var logic chipSelN,
    output var logic serialIn,
    input  wire logic serialOut,
    input  wire logic serialOutOeN
);
    logic [7:0] txq[$]; // bytes to send, msb first
    logic [7:0] rxq[$]; // bytes seen on the output
    initial begin
        linkClk = 1'b0; // mode 0, clock idles low
        chipSelN = 1'b1;
        serialIn = 1'b0;
    end
    // one frame of nb clocks; the clock stands still between frames
    task automatic xfer(input int nb);
        logic [7:0] rx;
        rxq = {};
        rx = 8'h00;
        #7 chipSelN = 1'b0;
        #20;
        for (int i = 0; i < nb; i++) begin
            serialIn = (i / 8 < txq.size()) ? txq[i / 8][7 - i % 8] : 1'b0;
            #15 linkClk = 1'b1;
            // a floating output reads unknown, so it never matches
            rx = {rx[6:0], serialOutOeN === 1'b0 ? serialOut : 1'bx};
            if (i % 8 == 7)
                rxq.push_back(rx);
            #15 linkClk = 1'b0;
        end
        #10 chipSelN = 1'b1;
        serialIn = ~serialIn; // released line shows no stale value
        #100;
    endtask : xfer
endmodule : sec_spi_host
`default_nettype wire

// file: testbench.sv
// self-checking bench of the eeprom command engine
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import sec_pkg::*;
    localparam int WT = 2000; // shortened internal write time
    logic ref_clk = 1'b0, sys_rst = 1'b1, holdN = 1'b1, writeProtectN = 1'b1;
    wire logic linkClk, chipSelN, serialIn, serialOut, serialOutOeN;
    wire logic writeInProgress, writeEnabled;
    int n_fail = 0, compares = 0;
    logic [7:0] mem [0:511]; // model array
    logic [1:0] bp = 2'h0; // model protect bits
    logic [31:0] lf = 32'h387f; // random source
    always #10 ref_clk = ~ref_clk;
    sec_engine #(.ADDR_W(9), .WRITE_TIME_NS(WT)) sec_engine_i (.ref_clk(ref_clk),
        .sys_rst(sys_rst), .linkClk(linkClk), .chipSelN(chipSelN), .serialIn(serialIn),
        .holdN(holdN), .writeProtectN(writeProtectN), .serialOut(serialOut),
        .serialOutOeN(serialOutOeN), .writeInProgress(writeInProgress),
        .writeEnabled(writeEnabled));
    sec_spi_host sec_spi_host_i (.linkClk(linkClk), .chipSelN(chipSelN),
        .serialIn(serialIn), .serialOut(serialOut), .serialOutOeN(serialOutOeN));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic close_out;
        if (n_fail == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : close_out
    // latch seen once the crossing has settled
    task automatic lat(input logic e);
        repeat (6) @(posedge ref_clk);
        chk("latch", {7'h0, e}, {7'h0, writeEnabled});
        chk("busy", 8'h00, {7'h0, writeInProgress});
    endtask : lat
    task automatic write_enable_cmd;
        sec_spi_host_i.txq = '{8'h06};
        sec_spi_host_i.xfer(8);
        lat(writeProtectN);
    endtask : write_enable_cmd
    task automatic status_read_cmd(input logic [7:0] e);
        sec_spi_host_i.txq = '{8'h05};
        sec_spi_host_i.xfer(24);
        chk("status", e, sec_spi_host_i.rxq[1]);
        chk("status repeat", e, sec_spi_host_i.rxq[2]);
    endtask : status_read_cmd
    task automatic wait_done;
        for (int i = 0; i < 400 && writeInProgress !== 1'b0; i++)
            @(posedge ref_clk);
        lat(1'b0);
    endtask : wait_done
    // memory write of n bytes, extra clocks make it a cancelled frame
    task automatic mwr(input logic [8:0] a, input int n, input int extra);
        logic ok;
        write_enable_cmd;
        ok = writeProtectN && extra == 0 && !(bp == 2'h3 || (bp == 2'h2 && a[8]) ||
            (bp == 2'h1 && a[8:7] == 2'h3));
        sec_spi_host_i.txq = '{8'h02 | {4'h0, a[8], 3'h0}, a[7:0]};
        for (int k = 0; k < n; k++) begin
            lf = lfsr(lf);
            sec_spi_host_i.txq.push_back(lf[7:0]);
            if (ok)
                mem[{a[8:4], a[3:0] + 4'(k)}] = lf[7:0];
        end
        sec_spi_host_i.xfer(16 + 8 * n + extra);
        if (ok)
            wait_done;
        else
            lat(writeProtectN);
    endtask : mwr
    task automatic mrd(input logic [8:0] a, input int n);
        sec_spi_host_i.txq = '{8'h03 | {4'h0, a[8], 3'h0}, a[7:0]};
        sec_spi_host_i.xfer(16 + 8 * n);
        for (int k = 0; k < n; k++)
            chk("read", mem[9'(a + k)], sec_spi_host_i.rxq[2 + k]);
    endtask : mrd
    task automatic status_write_cmd(input logic [7:0] d);
        write_enable_cmd;
        sec_spi_host_i.txq = '{8'h01, d};
        sec_spi_host_i.xfer(16);
        status_read_cmd({4'hf, bp, 2'h3});
        bp = d[3:2];
        wait_done;
        status_read_cmd({4'hf, bp, 2'h0});
    endtask : status_write_cmd
    initial begin
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        status_read_cmd(8'hf0);
        write_enable_cmd;
        sec_spi_host_i.txq = '{8'h04};
        sec_spi_host_i.xfer(9);
        lat(1'b1);
        @(posedge ref_clk) holdN <= 1'b0;
        sec_spi_host_i.xfer(8);
        @(posedge ref_clk) holdN <= 1'b1;
        lat(1'b1);
        sec_spi_host_i.xfer(8);
        lat(1'b0);
        mwr(9'h00e, 17, 0);
        mwr(9'h1f0, 16, 0);
        mwr(9'h1f0, 2, 1);
        mrd(9'h1fe, 4);
        status_write_cmd(8'hf7);
        mwr(9'h1f3, 1, 0);
        mwr(9'h040, 3, 0);
        status_write_cmd(8'h0b);
        mwr(9'h100, 1, 0);
        @(posedge ref_clk) writeProtectN <= 1'b0;
        mwr(9'h005, 1, 0);
        @(posedge ref_clk) writeProtectN <= 1'b1;
        mrd(9'h1f2, 2);
        mrd(9'h040, 3);
        mrd(9'h004, 3);
        close_out;
    end
    initial begin
        #500000;
        n_fail++;
        close_out;
    end
endmodule : testbench
`default_nettype wire
